// ---- core/hubf_top.v ----
// Host serial port: APB register slave, bit-rate divider, 8N1 transmitter
// and receiver. Assumes SYS_CLK at 200 MHz and an asynchronous RXD pin.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "hubf_map.vh"

// What this block does
// - With exponent zero, a bit lasts mantissa plus one reference periods.
// - With nonzero exponent, a bit lasts (mantissa+33)*2^(exponent-1) periods.
// - After reset the speed register holds 0x7A, giving 115.2 kbit/s.
// - Every character is one start bit, eight data bits and one stop bit.
// - No parity bit is sent or expected.
// - A write to the speed register changes the bit rate by the formulas.
// - The listed codes such as 0xEB, 0x1C and 0x15 give the standard rates.
module hubf_top (
  input  wire        SYS_CLK,
  input  wire        RST_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [9:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        RXD,
  output reg         TXD
);

  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_START = 2'b01;
  localparam [1:0] ST_DATA  = 2'b10;
  localparam [1:0] ST_STOP  = 2'b11;

  reg  [7:0]  speed_q;
  wire        ref_tick;
  wire [12:0] bit_div;

  reg  [1:0]  tx_st_q;
  reg  [12:0] tx_cnt_q;
  reg  [3:0]  tx_bit_q;
  reg  [7:0]  tx_sh_q;
  reg         tx_arm_q;

  reg         rx_s1_q;
  reg         rx_s2_q;
  reg         rx_s3_q;
  reg  [1:0]  rx_st_q;
  reg  [12:0] rx_cnt_q;
  reg  [3:0]  rx_bit_q;
  reg  [7:0]  rx_sh_q;
  reg  [7:0]  rx_data_q;
  reg         rx_valid_q;
  reg         frame_err_q;
  reg         overrun_q;

  wire [7:0]  idx;
  wire        acc_ok;
  wire        hit_speed;
  wire        hit_tx;
  wire        hit_rx;
  wire        hit_st;
  wire        wr;
  wire        rd;
  wire        tx_go;
  wire        rx_done;
  wire        rx_take;
  reg  [31:0] rd_mux;

  hubf_baud u_baud (
    .clk      (SYS_CLK),
    .rst_n    (RST_N),
    .speed    (speed_q),
    .ref_tick (ref_tick),
    .bit_div  (bit_div)
  );

  // Last reference tick of a period of div ticks
  function last_tick;
    input [12:0] cnt;
    input [12:0] div;
    begin
      last_tick = (cnt >= div - 13'h0_001);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; one wait state so that every output comes from a flip-flop
  assign idx       = PADDR[9:2];
  assign acc_ok    = PSEL && PENABLE && PREADY;
  assign hit_speed = (idx == `HUBF_IDX_SPEED)  && (PADDR[1:0] == 2'b00);
  assign hit_tx    = (idx == `HUBF_IDX_TXDATA) && (PADDR[1:0] == 2'b00);
  assign hit_rx    = (idx == `HUBF_IDX_RXDATA) && (PADDR[1:0] == 2'b00);
  assign hit_st    = (idx == `HUBF_IDX_STATUS) && (PADDR[1:0] == 2'b00);
  assign wr        = acc_ok && PWRITE;
  assign rd        = acc_ok && !PWRITE;
  assign tx_go     = wr && hit_tx && (tx_st_q == ST_IDLE) && !tx_arm_q;
  assign rx_take   = rd && hit_rx;

  always @* begin
    rd_mux = 32'h0000_0000;
    if (hit_speed) begin
      rd_mux[7:0] = speed_q;
    end else if (hit_rx) begin
      rd_mux[7:0] = rx_data_q;
    end else if (hit_st) begin
      rd_mux[`HUBF_ST_TX_BUSY]   = (tx_st_q != ST_IDLE) || tx_arm_q;
      rd_mux[`HUBF_ST_RX_VALID]  = rx_valid_q;
      rd_mux[`HUBF_ST_FRAME_ERR] = frame_err_q;
      rd_mux[`HUBF_ST_OVERRUN]   = overrun_q;
    end
  end

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY &&
                 !(hit_speed || hit_tx || hit_rx || hit_st);
      if (PSEL && PENABLE && !PREADY && !PWRITE) begin
        PRDATA <= rd_mux;
      end
    end
  end

  // Speed register; a new value reaches bit_div one cycle later, even in the middle of a bit
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      speed_q <= `HUBF_SPEED_RESET;
    end else if (wr && hit_speed) begin
      speed_q <= PWDATA[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter; a write while busy is dropped, software polls the busy bit
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      tx_st_q  <= ST_IDLE;
      tx_cnt_q <= 13'h0_000;
      tx_bit_q <= 4'h0;
      tx_sh_q  <= 8'h00;
      tx_arm_q <= 1'b0;
      TXD      <= 1'b1;
    end else begin
      case (tx_st_q)
        ST_IDLE: begin
          TXD <= 1'b1;
          if (tx_go) begin
            tx_sh_q  <= PWDATA[7:0];
            tx_arm_q <= 1'b1;
          end else if (tx_arm_q && ref_tick) begin
            // Start on a reference tick, else the start bit comes out short
            tx_arm_q <= 1'b0;
            tx_cnt_q <= 13'h0_000;
            tx_st_q  <= ST_START;
            TXD      <= 1'b0;
          end
        end
        default: begin
          if (ref_tick) begin
            if (last_tick(tx_cnt_q, bit_div)) begin
              tx_cnt_q <= 13'h0_000;
              case (tx_st_q)
                ST_START: begin
                  tx_st_q  <= ST_DATA;
                  tx_bit_q <= 4'h0;
                  TXD      <= tx_sh_q[0];
                  tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                end
                ST_DATA: begin
                  if (tx_bit_q == `HUBF_DATA_BITS - 4'h1) begin
                    tx_st_q <= ST_STOP;
                    TXD     <= 1'b1;
                  end else begin
                    tx_bit_q <= tx_bit_q + 4'h1;
                    TXD      <= tx_sh_q[0];
                    tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                  end
                end
                default: begin
                  tx_st_q <= ST_IDLE;
                  TXD     <= 1'b1;
                end
              endcase
            end else begin
              tx_cnt_q <= tx_cnt_q + 13'h0_001;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver; RXD crosses in on two flip-flops before anything reads it
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      // Third stage feeds only the start edge detector; idles high
      rx_s3_q <= 1'b1;
    end else begin
      rx_s1_q <= RXD;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  // Stop bit centre: data and flags are taken here
  assign rx_done = ref_tick && (rx_st_q == ST_STOP) &&
                   last_tick(rx_cnt_q, bit_div);

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rx_st_q  <= ST_IDLE;
      rx_cnt_q <= 13'h0_000;
      rx_bit_q <= 4'h0;
      rx_sh_q  <= 8'h00;
    end else begin
      case (rx_st_q)
        ST_IDLE: begin
          rx_cnt_q <= 13'h0_000;
          // Falling edge only, so a low stop bit cannot restart the receiver
          if (rx_s3_q && !rx_s2_q) begin
            rx_st_q <= ST_START;
          end
        end
        ST_START: begin
          // Half a bit in: mid start bit; a glitch returns to idle
          if (ref_tick) begin
            if (last_tick(rx_cnt_q, {1'b0, bit_div[12:1]})) begin
              rx_cnt_q <= 13'h0_000;
              rx_bit_q <= 4'h0;
              rx_st_q  <= rx_s2_q ? ST_IDLE : ST_DATA;
            end else begin
              rx_cnt_q <= rx_cnt_q + 13'h0_001;
            end
          end
        end
        ST_DATA: begin
          if (ref_tick) begin
            if (last_tick(rx_cnt_q, bit_div)) begin
              rx_cnt_q <= 13'h0_000;
              rx_sh_q  <= {rx_s2_q, rx_sh_q[7:1]};
              if (rx_bit_q == `HUBF_DATA_BITS - 4'h1) begin
                rx_st_q <= ST_STOP;
              end else begin
                rx_bit_q <= rx_bit_q + 4'h1;
              end
            end else begin
              rx_cnt_q <= rx_cnt_q + 13'h0_001;
            end
          end
        end
        default: begin
          if (ref_tick) begin
            if (last_tick(rx_cnt_q, bit_div)) begin
              rx_cnt_q <= 13'h0_000;
              rx_st_q  <= ST_IDLE;
            end else begin
              rx_cnt_q <= rx_cnt_q + 13'h0_001;
            end
          end
        end
      endcase
    end
  end

  // Received character and flags; a new event wins over a same-cycle clear
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rx_data_q   <= 8'h00;
      rx_valid_q  <= 1'b0;
      frame_err_q <= 1'b0;
      overrun_q   <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_data_q  <= rx_sh_q;
        rx_valid_q <= 1'b1;
      end else if (rx_take) begin
        rx_valid_q <= 1'b0;
      end
      if (rx_done && !rx_s2_q) begin
        frame_err_q <= 1'b1;
      end else if (wr && hit_st && PWDATA[`HUBF_ST_FRAME_ERR]) begin
        frame_err_q <= 1'b0;
      end
      if (rx_done && rx_valid_q && !rx_take) begin
        overrun_q <= 1'b1;
      end else if (wr && hit_st && PWDATA[`HUBF_ST_OVERRUN]) begin
        overrun_q <= 1'b0;
      end
    end
  end

endmodule

// ---- core/hubf_map.vh ----
// Register map, field layout and timing constants of the host serial port.
// Assumes inclusion by the serial port modules only; definitions only.
`ifndef HUBF_MAP_VH
`define HUBF_MAP_VH

// Register indices; the byte address on the bus is four times the index
`define HUBF_IDX_SPEED      8'h3B
`define HUBF_IDX_TXDATA     8'h40
`define HUBF_IDX_RXDATA     8'h41
`define HUBF_IDX_STATUS     8'h42

// Speed register layout and reset value
`define HUBF_SPEED_RESET    8'h7A
`define HUBF_DIV_RESET      13'h00EC
`define HUBF_EXP_MSB        7
`define HUBF_EXP_LSB        5
`define HUBF_MANT_MSB       4
`define HUBF_MANT_LSB       0
`define HUBF_MANT_OFS_ZERO  13'h0001
`define HUBF_MANT_OFS_EXP   13'h0021

// Status register bit positions
`define HUBF_ST_TX_BUSY     0
`define HUBF_ST_RX_VALID    1
`define HUBF_ST_FRAME_ERR   2
`define HUBF_ST_OVERRUN     3

// Framing: data bits per character
`define HUBF_DATA_BITS      4'h8

// Bit-rate reference and system clock, in kHz
`define HUBF_REF_KHZ        27120
`define HUBF_SYS_KHZ        200000

`endif

// ---- core/hubf_baud.v ----
// Reference tick and bit-period generator for the host serial port.
// Assumes a free-running system clock faster than the 27.12 MHz reference.
`timescale 1ns/1ps
`include "hubf_map.vh"

module hubf_baud #(
  parameter REF_KHZ = `HUBF_REF_KHZ,
  parameter SYS_KHZ = `HUBF_SYS_KHZ
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  speed,
  output reg         ref_tick,
  output reg  [12:0] bit_div
);

  localparam [17:0] REF_STEP = REF_KHZ;
  localparam [17:0] SYS_WRAP = SYS_KHZ;

  reg  [17:0] acc_q;
  wire [17:0] acc_sum;
  wire [2:0]  exp_f;
  wire [4:0]  mant_f;

  assign acc_sum = acc_q + REF_STEP;
  assign exp_f   = speed[`HUBF_EXP_MSB:`HUBF_EXP_LSB];
  assign mant_f  = speed[`HUBF_MANT_MSB:`HUBF_MANT_LSB];

  // Reference ticks per bit for a given exponent and mantissa
  function [12:0] div_of;
    input [2:0] e;
    input [4:0] m;
    reg   [12:0] base;
    begin
      if (e == 3'h0) begin
        base   = {8'h00, m} + `HUBF_MANT_OFS_ZERO;
        div_of = base;
      end else begin
        base   = {8'h00, m} + `HUBF_MANT_OFS_EXP;
        div_of = base << (e - 3'h1);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Phase accumulator: average tick rate equals the reference, with jitter
  // of one system clock, well inside a bit period at the fastest rate
  always @(posedge clk) begin
    if (!rst_n) begin
      acc_q    <= 18'h0_0000;
      ref_tick <= 1'b0;
      bit_div  <= `HUBF_DIV_RESET;
    end else begin
      if (acc_sum >= SYS_WRAP) begin
        acc_q    <= acc_sum - SYS_WRAP;
        ref_tick <= 1'b1;
      end else begin
        acc_q    <= acc_sum;
        ref_tick <= 1'b0;
      end
      bit_div <= div_of(exp_f, mant_f);
    end
  end

endmodule

// ---- verification/hubf_props.sv ----
// Checker for the host serial port pins and its APB slave.
// Assumes a bind to hubf_top; one clock, RST_N synchronous and low.
`timescale 1ns/1ps
module hubf_props (
  input wire        SYS_CLK,
  input wire        RST_N,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [9:0]  PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire        RXD,
  input wire        TXD
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  wire acc   = PSEL && PENABLE && !PREADY;
  wire tx_wr = PREADY && PWRITE && !PSLVERR && PADDR == 10'h100;
  ////////////////////////////////////////////////////////////////////////
  AST_ACC_WAIT: assert property ($rose(PSEL && PENABLE) |->
    !PREADY ##1 PREADY) else $error("ready not on second access edge");
  AST_RDY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_RDY_IDLE: assert property (!PSEL |=> !PREADY)
    else $error("ready without select");
  AST_ERR_PAIR: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  AST_MISALIGN: assert property (acc && PADDR[1:0] != 2'b00 |=> PSLVERR)
    else $error("misaligned access accepted");
  AST_SPEED_OK: assert property (acc && PADDR == 10'h0EC |=>
    PREADY && !PSLVERR) else $error("speed register refused");
  AST_UPPER_ZERO: assert property (PREADY && !PWRITE |->
    PRDATA[31:8] == 24'h00_0000) else $error("upper read bits set");
  AST_RESET_IDLE: assert property ($rose(RST_N) |-> TXD)
    else $error("line not idle after reset");
  // Start bit waits for the next reference tick, at most eight cycles
  AST_TX_START: assert property (tx_wr |-> ##[2:9] !TXD)
    else $error("no start bit after data write");
  // Shortest bit is seven cycles, so any low level must outlast six
  AST_LOW_MIN: assert property ($fell(TXD) |=> !TXD [*6])
    else $error("bit shorter than one period");
  ////////////////////////////////////////////////////////////////////////
  cover property (tx_wr);
  cover property (PSLVERR);
  cover property ($fell(TXD));
endmodule

// ---- verification/hubf_host.sv ----
// Behavioural host serial port facing the block's TXD and RXD pins.
// Assumes the bench sets bit_ns before each character.
`timescale 1ns/1ps
module hubf_host (
  input  wire  txd,
  output logic rxd
);
  real bit_ns = 8680.0;
  // Line idles high; rates are kept at or below the supported top
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] b, input logic stop);
    rxd = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      rxd = b[i];
      #(bit_ns);
    end
    rxd = stop;
    #(bit_ns);
    rxd = 1'b1;
  endtask
  // First data bit must be one so the start bit ends on an edge
  task automatic recv(output logic [7:0] b, output logic stop, output real w);
    realtime t0;
    @(negedge txd);
    t0 = $realtime;
    @(posedge txd);
    w = $realtime - t0;
    #(bit_ns / 2.0);
    for (int i = 0; i < 8; i++) begin
      b[i] = txd;
      #(bit_ns);
    end
    stop = txd;
  endtask
endmodule

// ---- verification/host_uart_baud_and_framing_tb_top.sv ----
// Bench for the host serial port: APB master tasks and a host model.
// Assumes hubf_top and the checker and host model compiled before it.
`timescale 1ns/1ps
module host_uart_baud_and_framing_tb_top;
  logic        SYS_CLK = 1'b0;
  logic        RST_N, PSEL, PENABLE, PWRITE;
  logic [9:0]  PADDR;
  logic [31:0] PWDATA, rd;
  wire  [31:0] PRDATA;
  wire         PREADY, PSLVERR, TXD, RXD;
  int          mismatches = 0;
  int          comparisons = 0;
  int          dv;
  logic        err, stp, ok;
  logic [7:0]  rb, c, db;
  real         w;
  logic [7:0]  codes [5] = '{8'h7A, 8'h15, 8'h1C, 8'h3A, 8'h5A};
  hubf_top dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD),
    .TXD(TXD));
  hubf_host host (.txd(TXD), .rxd(RXD));
  initial forever #2.5 SYS_CLK = ~SYS_CLK;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n == 50) check(32'h0000_0000, 32'h0000_0001);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Status is polled until the receive flag sets, which happens at the stop bit centre
  task automatic rx_char(input logic [7:0] b, input logic stop,
                         input logic [31:0] st);
    int n;
    n = 0;
    host.send(b, stop);
    do begin
      apb(1'b0, 10'h108, 32'h0000_0000);
      n++;
    end while (rd[1] !== 1'b1 && n < 40);
    check(rd, st);
    apb(1'b0, 10'h104, 32'h0000_0000);
    check(rd, {24'h00_0000, b});
  endtask
  task automatic close_out;
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge SYS_CLK);
    mismatches++;
    close_out;
  end
  initial begin
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 10'h000;
    PWDATA = 32'h0000_0000;
    repeat (16) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    apb(1'b0, 10'h3FC, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    // Misaligned write must leave the default rate in place
    apb(1'b1, 10'h0ED, 32'h0000_0015);
    check({31'h0000_0000, err}, 32'h0000_0001);
    for (int i = 0; i < 5; i++) begin
      c = codes[i];
      db = 8'h35 + 8'h22 * i[7:0];
      if (i > 0) apb(1'b1, 10'h0EC, {24'h00_0000, c});
      apb(1'b0, 10'h0EC, 32'h0000_0000);
      check(rd, {24'h00_0000, c});
      dv = (c[7:5] == 3'h0) ? c[4:0] + 1 : (c[4:0] + 33) << (c[7:5] - 1);
      host.bit_ns = dv * 1.0e6 / 27120.0;
      fork
        host.recv(rb, stp, w);
        begin
          apb(1'b1, 10'h100, {24'h00_0000, db});
          apb(1'b0, 10'h108, 32'h0000_0000);
          check(rd, 32'h0000_0001);
        end
      join
      check({24'h00_0000, rb}, {24'h00_0000, db});
      check({31'h0000_0000, stp}, 32'h0000_0001);
      ok = w > host.bit_ns - 15.0 && w < host.bit_ns + 15.0;
      check({31'h0000_0000, ok}, 32'h0000_0001);
      rx_char(~db, 1'b1, 32'h0000_0002);
    end
    apb(1'b1, 10'h0EC, 32'h0000_0015);
    host.bit_ns = 22 * 1.0e6 / 27120.0;
    rx_char(8'h3C, 1'b0, 32'h0000_0006);
    apb(1'b1, 10'h108, 32'h0000_0004);
    apb(1'b0, 10'h108, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // Second character with the first unread sets overrun
    host.send(8'hA5, 1'b1);
    repeat (4) @(posedge SYS_CLK);
    rx_char(8'h5A, 1'b1, 32'h0000_000A);
    apb(1'b1, 10'h108, 32'h0000_0008);
    apb(1'b0, 10'h108, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    close_out;
  end
endmodule
bind hubf_top hubf_props u_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .RXD(RXD), .TXD(TXD));
